/* File: bench/shcp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// smbus host, open-drain data line
// ----------------------------------------
module shcp_host_model (
    output logic scl,
    output logic sda,
    input wire logic dev_out,
    input wire logic dev_oe
);
    logic pull_low = 1'b0;
    // released line floats high through the pull-up
    assign sda = !(pull_low || (dev_oe && !dev_out));
    initial begin
        scl = 1'b1;
    end
    // short pulses only clear the link-side reset chain
    task automatic pulse();
        repeat (3) begin
            #15 scl = 1'b0;
            #15 scl = 1'b1;
        end
    endtask
    // also serves as repeated start when entered with scl low
    task automatic start();
        #60 pull_low = 1'b0;
        #40 scl = 1'b1;
        #60 pull_low = 1'b1;
        #60 scl = 1'b0;
    endtask
    task automatic stop();
        #60 pull_low = 1'b1;
        #40 scl = 1'b1;
        #60 pull_low = 1'b0;
    endtask
    // data moves well after the fall, sampled halfway through the high phase
    task automatic bitx(input logic b, output logic r);
        #60 pull_low = !b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(a9, r);
        ack = !r;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic addr_sel = 1'b0;
    logic pswitch_ack = 1'b0;
    logic [7:0] pswitch_rdata = 8'h00;
    logic [39:0] port_connect = 40'h0;
    wire scl;
    wire sda;
    logic dout, oe, req, boot, cfg, attach, smb_en, busy, ps_wr;
    logic [14:0] pdis;
    logic [7:0] ps_addr;
    int err_total = 0, comparisons = 0, cyc = 0, n_boot = 0, n_cfg = 0, n_req = 0;
    shcp_command_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .smb_clk(scl),
        .serial_management_data_line_in(sda), .serial_management_data_line_out(dout),
        .serial_management_data_line_oe(oe), .addr_sel(addr_sel), .hub_info(8'h3C),
        .pswitch_mask(8'h06), .port_connect(port_connect), .port_power(5'h15),
        .port_dpdm(40'h0), .pswitch_ack(pswitch_ack), .pswitch_rdata(pswitch_rdata),
        .pswitch_req(req), .pswitch_write(ps_wr), .pswitch_addr(ps_addr), .pswitch_wdata(),
        .port_disable(pdis), .mcu_reboot(boot), .cfg_access(cfg), .usb_attach(attach),
        .smbus_enable(smb_en), .exec_busy(busy));
    shcp_host_model host (.scl(scl), .sda(sda), .dev_out(dout), .dev_oe(oe));
    always #5 clk_sys = ~clk_sys;
    // pulses are one cycle wide, so count them as they pass
    always @(posedge clk_sys) begin
        if (boot === 1'b1) n_boot++;
        if (cfg === 1'b1) n_cfg++;
        if (req === 1'b1) n_req++;
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // stops at the first refused byte, as the port ignores the rest
    task automatic wr(input logic [7:0] b [$], input int ek);
        logic [7:0] q;
        logic a;
        int nk;
        nk = -1;
        host.start();
        foreach (b[i]) if (nk < 0) begin
            host.xfer(b[i], 1'b1, q, a);
            if (a !== 1'b1) nk = i;
        end
        host.stop();
        chk(8'(nk), 8'(ek));
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] e [$]);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer(8'h58, 1'b1, q, a);
        host.xfer(8'h00, 1'b1, q, a);
        host.xfer(ofs, 1'b1, q, a);
        host.start();
        host.xfer(8'h59, 1'b1, q, a);
        foreach (e[i]) begin
            host.xfer(8'hFF, i == e.size() - 1, q, a);
            chk(q, e[i]);
        end
        host.stop();
    endtask
    task automatic xc(input logic [7:0] aw, input logic [7:0] c, input logic [7:0] p);
        wr({aw, 8'h00, 8'h00, 8'h03, c, 8'h00, p}, -1);
        wr({aw, 8'h99, 8'h3E, 8'h00}, -1);
        repeat (20) @(posedge clk_sys);
    endtask
    task automatic idle();
        for (int i = 0; i < 500 && busy !== 1'b0; i++) @(posedge clk_sys);
        chk({7'h0, busy}, 8'h00);
    endtask
    task automatic t_addr();
        chk({5'h0, smb_en, attach, busy}, 8'h04);
        wr({8'h54}, 0);
        wr({8'h5A}, 0);
        wr({8'h58}, -1);
    endtask
    task automatic t_block();
        wr({8'h58, 8'h00, 8'h10, 8'h03, 8'hA5, 8'h3C, 8'h81}, -1);
        rd(8'h10, {8'h20, 8'hA5, 8'h3C, 8'h81});
        rd(8'h11, {8'h20, 8'h3C});
        wr({8'h58, 8'h00, 8'h20, 8'h00}, 3);
        wr({8'h58, 8'h00, 8'h20, 8'h21}, 3);
        wr({8'h58, 8'h00, 8'h20, 8'h01, 8'h11, 8'h22}, 5);
        rd(8'h20, {8'h20, 8'h11});
    endtask
    task automatic t_ext();
        logic [7:0] codes [$] = {8'h01, 8'h02, 8'h03, 8'h82, 8'h83};
        logic [7:0] exp [$] = {8'h2C, 8'h3C, 8'h06, 8'h00, 8'h00};
        @(posedge clk_sys);
        port_connect <= 40'h9A_78_56_34_12;
        xc(8'h58, 8'h80, 8'h1F);
        idle();
        rd(8'h00, {8'h20, 8'h80, 8'h01, 8'h1F, 8'h12, 8'h34});
        xc(8'h58, 8'h81, 8'h1F);
        idle();
        rd(8'h01, {8'h20, 8'h01, 8'h1F, 8'h01, 8'h00, 8'h01});
        foreach (codes[i]) begin
            xc(8'h58, codes[i], 8'h00);
            idle();
            rd(8'h01, {8'h20, 8'h01, exp[i]});
        end
        wr({8'h58, 8'h00, 8'h03, 8'h01, 8'h85}, -1);
        xc(8'h58, 8'h82, 8'h01);
        chk({5'h0, pdis[2:0]}, 8'h05);
        xc(8'h58, 8'h7F, 8'h00);
        idle();
        rd(8'h01, {8'h20, 8'h02});
    endtask
    task automatic t_ps();
        for (int c = 0; c < 4; c++) begin
            xc(8'h58, 8'h84 + 8'(c), 8'h55);
            chk({7'h0, busy}, 8'h01);
            chk(ps_addr, 8'h55);
            chk({7'h0, ps_wr}, {7'h0, c[0]});
            chk(8'(n_req), 8'(c + 1));
            pswitch_ack <= 1'b1;
            pswitch_rdata <= 8'h5A;
            @(posedge clk_sys);
            pswitch_ack <= 1'b0;
            idle();
            if (c == 0) rd(8'h01, {8'h20, 8'h01, 8'h55, 8'h5A});
            else rd(8'h01, {8'h20, 8'h01, 8'h55});
        end
    endtask
    task automatic t_setaddr();
        xc(8'h58, 8'h00, 8'h2E);
        idle();
        wr({8'h58}, 0);
        wr({8'h5C}, -1);
        xc(8'h5C, 8'h00, 8'h80);
        idle();
        wr({8'h58}, -1);
    endtask
    task automatic t_special();
        wr({8'h58, 8'h99, 8'h36, 8'h00}, -1);
        wr({8'h58, 8'h99, 8'h37, 8'h00}, -1);
        wr({8'h58, 8'h99, 8'h37, 8'h01}, 3);
        wr({8'h58, 8'h99, 8'h00, 8'h00}, -1);
        repeat (20) @(posedge clk_sys);
        chk(8'(n_boot * 16 + n_cfg), 8'h11);
        chk({6'h0, attach, smb_en}, 8'h01);
        wr({8'h58, 8'hAA, 8'h56, 8'h00}, -1);
        repeat (20) @(posedge clk_sys);
        chk({6'h0, attach, smb_en}, 8'h03);
        wr({8'h58, 8'hAA, 8'h55, 8'h00}, -1);
        repeat (20) @(posedge clk_sys);
        chk({6'h0, attach, smb_en}, 8'h02);
        wr({8'h58}, 0);
    endtask
    initial begin
        fork
            host.pulse();
        join_none
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        // link reset chain needs host clock edges after release too
        host.pulse();
        repeat (20) @(posedge clk_sys);
        t_addr();
        t_block();
        t_ext();
        t_ps();
        t_setaddr();
        t_special();
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: logic/shcp_command_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shcp_map.svh"
// Behaviour
// RULE1 - answer one of two strap-selected 7-bit addresses, ignore all others
// RULE2 - buffer access is address, 16-bit offset, then data bytes
// RULE3 - all bytes on the data line move most significant bit first
// RULE4 - host write sends address, offset, byte count, then that many bytes
// RULE5 - host never sends a zero byte count
// RULE6 - one block transfer moves at most 32 data bytes
// RULE7 - block read turns direction by repeated start and read address
// RULE8 - special opcode takes the offset place, terminated by one 00h byte
// RULE9 - 9936h reboots controller, 9937h opens config access, 993Eh runs command
// RULE10 - AA55h attaches and drops serial access, AA56h attaches and keeps it
// RULE11 - decode extended codes 00h-03h and 80h-87h
// RULE12 - extended command code is taken from buffer offset 0000h
// RULE13 - status byte at 0001h is overwritten with the execution status
// RULE14 - parameters start at 0002h, results follow at consecutive offsets
// RULE15 - host writes command block first, then sends the execute opcode
// RULE16 - host reads results and may stop the read at any byte
// RULE17 - set-address command replaces the slave address with the parameter
// RULE18 - opcodes act only after terminator and stop; unknown ones ignored
module shcp_command_port
    import shcp_pkg::*;
#(
    parameter int NUM_PORTS = 5,
    parameter int RAM_AW = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic smb_clk,
    input wire logic serial_management_data_line_in,
    output logic serial_management_data_line_out,
    output logic serial_management_data_line_oe,
    input wire logic addr_sel,
    input wire logic [7:0] hub_info,
    input wire logic [7:0] pswitch_mask,
    input wire logic [NUM_PORTS*8-1:0] port_connect,
    input wire logic [NUM_PORTS-1:0] port_power,
    input wire logic [NUM_PORTS*8-1:0] port_dpdm,
    input wire logic pswitch_ack,
    input wire logic [7:0] pswitch_rdata,
    output logic pswitch_req,
    output logic pswitch_write,
    output logic [7:0] pswitch_addr,
    output logic [7:0] pswitch_wdata,
    output logic [NUM_PORTS*3-1:0] port_disable,
    output logic mcu_reboot,
    output logic cfg_access,
    output logic usb_attach,
    output logic smbus_enable,
    output logic exec_busy
);
    // ----------------------------------------
    // link domain: bit capture on host clock
    // ----------------------------------------
    logic [1:0] link_rst_sync_reg;
    logic link_bit_reg, link_tog_reg;
    always_ff @(posedge smb_clk) begin
        link_rst_sync_reg <= {link_rst_sync_reg[0], rst_n};
        if (!link_rst_sync_reg[1]) begin
            link_tog_reg <= 1'b0;
            link_bit_reg <= 1'b1;
        end else begin
            link_tog_reg <= ~link_tog_reg;
            link_bit_reg <= serial_management_data_line_in;
        end
    end

    // ----------------------------------------
    // synchronisers and line events
    // ----------------------------------------
    logic [2:0] scl_sync_reg, sda_sync_reg, tog_sync_reg;
    logic scl_lvl_reg, sda_lvl_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            tog_sync_reg <= 3'h0;
            scl_lvl_reg <= 1'b1;
            sda_lvl_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], smb_clk};
            sda_sync_reg <= {sda_sync_reg[1:0], serial_management_data_line_in};
            tog_sync_reg <= {tog_sync_reg[1:0], link_tog_reg};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_lvl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_lvl_reg <= sda_sync_reg[2];
            end
        end
    end
    logic scl_hi, sda_new_lo, sda_new_hi, start_ev, stop_ev, fall_ev, rise_ev;
    assign scl_hi = scl_lvl_reg & scl_sync_reg[1] & scl_sync_reg[2];
    assign sda_new_lo = ~sda_sync_reg[1] & ~sda_sync_reg[2];
    assign sda_new_hi = sda_sync_reg[1] & sda_sync_reg[2];
    assign start_ev = scl_hi & sda_lvl_reg & sda_new_lo;
    assign stop_ev = scl_hi & ~sda_lvl_reg & sda_new_hi;
    assign fall_ev = scl_lvl_reg & ~scl_sync_reg[1] & ~scl_sync_reg[2];
    // the held bit is stable for a whole host clock, so the toggle carries it
    assign rise_ev = tog_sync_reg[1] ^ tog_sync_reg[2];

    // ----------------------------------------
    // byte protocol engine
    // ----------------------------------------
    logic [7:0] ram [0:(1<<RAM_AW)-1];
    shcp_phase_type phase_reg;
    shcp_exec_type exec_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_reg, tx_reg, count_reg, rd_byte;
    logic [15:0] ofs_reg;
    logic [6:0] slave_addr_reg, default_addr_reg;
    logic special_reg, term_reg, read_first_reg, mnack_reg, sda_oe_reg, sda_out_reg;
    logic host_we_reg, op_go_reg, smbus_en_reg;
    logic [RAM_AW-1:0] host_wa_reg;
    logic [7:0] host_wd_reg;
    assign rd_byte = read_first_reg ? `SHCP_BLOCK_MAX : ram[ofs_reg[RAM_AW-1:0]];
    always_ff @(posedge clk_sys) begin
        host_we_reg <= 1'b0;
        op_go_reg <= 1'b0;
        sda_out_reg <= 1'b0;
        if (!rst_n) begin
            phase_reg <= PH_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            ofs_reg <= 16'h0000;
            count_reg <= 8'h00;
            special_reg <= 1'b0;
            term_reg <= 1'b0;
            read_first_reg <= 1'b0;
            mnack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            host_wa_reg <= '0;
            host_wd_reg <= 8'h00;
        end else if (start_ev) begin
            // repeated start keeps the offset for the read that follows
            phase_reg <= smbus_en_reg ? PH_ADDR : PH_IGNORE; // RULE7 RULE10
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            term_reg <= 1'b0;
        end else if (stop_ev) begin
            phase_reg <= PH_IDLE; // RULE16
            sda_oe_reg <= 1'b0;
            op_go_reg <= term_reg & special_reg; // RULE18
            term_reg <= 1'b0;
        end else if (rise_ev && phase_reg != PH_IDLE) begin
            if (bit_cnt_reg == 4'h8) begin
                mnack_reg <= link_bit_reg;
                bit_cnt_reg <= 4'h0;
            end else begin
                rx_reg <= {rx_reg[6:0], link_bit_reg}; // RULE3
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end else if (fall_ev && bit_cnt_reg == 4'h8) begin
            sda_oe_reg <= 1'b0;
            case (phase_reg)
                PH_ADDR: begin
                    if (rx_reg[7:1] == slave_addr_reg && exec_reg == EX_IDLE) begin // RULE1
                        sda_oe_reg <= 1'b1;
                        phase_reg <= rx_reg[0] ? PH_RDATA : PH_OFS_HI; // RULE7
                        read_first_reg <= 1'b1;
                        count_reg <= `SHCP_BLOCK_MAX;
                    end else begin
                        phase_reg <= PH_IGNORE;
                    end
                end
                PH_OFS_HI: begin
                    ofs_reg[15:8] <= rx_reg; // RULE2
                    sda_oe_reg <= 1'b1;
                    phase_reg <= PH_OFS_LO;
                end
                PH_OFS_LO: begin
                    ofs_reg[7:0] <= rx_reg;
                    special_reg <= (ofs_reg[15:8] == `SHCP_OP_REBOOT >> 8) ||
                                   (ofs_reg[15:8] == `SHCP_OP_ATTACH >> 8); // RULE8
                    sda_oe_reg <= 1'b1;
                    phase_reg <= PH_COUNT;
                end
                PH_COUNT: begin
                    if (special_reg) begin
                        term_reg <= rx_reg == `SHCP_TERM_BYTE; // RULE8
                        sda_oe_reg <= rx_reg == `SHCP_TERM_BYTE;
                        phase_reg <= PH_IGNORE;
                    end else if (rx_reg == 8'h00 || rx_reg > `SHCP_BLOCK_MAX) begin
                        phase_reg <= PH_IGNORE; // RULE5 RULE6
                    end else begin
                        count_reg <= rx_reg; // RULE4
                        sda_oe_reg <= 1'b1;
                        phase_reg <= PH_WDATA;
                    end
                end
                PH_WDATA: begin
                    host_we_reg <= 1'b1;
                    host_wa_reg <= ofs_reg[RAM_AW-1:0];
                    host_wd_reg <= rx_reg;
                    ofs_reg <= ofs_reg + 16'h0001;
                    count_reg <= count_reg - 8'h01;
                    sda_oe_reg <= 1'b1;
                    if (count_reg == 8'h01) begin
                        phase_reg <= PH_IGNORE; // RULE6
                    end
                end
                default: begin
                end
            endcase
        end else if (fall_ev && bit_cnt_reg == 4'h0 && phase_reg == PH_RDATA) begin
            if (read_first_reg || (!mnack_reg && count_reg != 8'h00)) begin
                sda_oe_reg <= ~rd_byte[7]; // RULE3
                tx_reg <= {rd_byte[6:0], 1'b0};
                read_first_reg <= 1'b0;
                if (!read_first_reg) begin
                    ofs_reg <= ofs_reg + 16'h0001;
                    count_reg <= count_reg - 8'h01; // RULE6
                end
            end else begin
                sda_oe_reg <= 1'b0; // RULE16
                phase_reg <= PH_IGNORE;
            end
        end else if (fall_ev && bit_cnt_reg == 4'h0) begin
            sda_oe_reg <= 1'b0;
        end else if (fall_ev && phase_reg == PH_RDATA) begin
            sda_oe_reg <= ~tx_reg[7]; // RULE3 RULE7
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // opcode dispatch, extended commands, buffer
    // ----------------------------------------
    logic [7:0] xcode, xparam;
    assign xcode = ram[`SHCP_IDX_CODE];
    assign xparam = ram[`SHCP_IDX_PARAM];
    function automatic logic [7:0] port_byte(input logic [7:0] code, input int i);
        if (code == `SHCP_XC_CONNECT) begin
            port_byte = port_connect[i*8 +: 8];
        end else if (code == `SHCP_XC_POWER) begin
            port_byte = {7'h00, port_power[i]};
        end else begin
            port_byte = port_dpdm[i*8 +: 8];
        end
    endfunction
    logic strap_taken_reg, reboot_reg, cfg_reg, attach_reg, ps_req_reg, ps_wr_reg, busy_reg;
    logic [7:0] ps_addr_reg, ps_wdata_reg;
    logic [NUM_PORTS*3-1:0] port_dis_reg;
    always_ff @(posedge clk_sys) begin
        reboot_reg <= 1'b0;
        cfg_reg <= 1'b0;
        ps_req_reg <= 1'b0;
        if (!rst_n) begin
            exec_reg <= EX_IDLE;
            busy_reg <= 1'b0;
            strap_taken_reg <= 1'b0;
            slave_addr_reg <= `SHCP_ADDR_A;
            default_addr_reg <= `SHCP_ADDR_A;
            attach_reg <= 1'b0;
            smbus_en_reg <= 1'b1;
            ps_wr_reg <= 1'b0;
            ps_addr_reg <= 8'h00;
            ps_wdata_reg <= 8'h00;
            port_dis_reg <= '0;
        end else begin
            busy_reg <= exec_reg != EX_IDLE;
            // strap is caught once, after reset release
            if (!strap_taken_reg) begin
                strap_taken_reg <= 1'b1;
                slave_addr_reg <= addr_sel ? `SHCP_ADDR_B : `SHCP_ADDR_A; // RULE1
                default_addr_reg <= addr_sel ? `SHCP_ADDR_B : `SHCP_ADDR_A;
            end
            if (host_we_reg) begin
                ram[host_wa_reg] <= host_wd_reg; // RULE2
            end
            case (exec_reg)
                EX_IDLE: begin
                    if (op_go_reg) begin
                        case (ofs_reg)
                            `SHCP_OP_REBOOT: reboot_reg <= 1'b1; // RULE9
                            `SHCP_OP_CFG: cfg_reg <= 1'b1; // RULE9
                            `SHCP_OP_EXT: exec_reg <= EX_RUN; // RULE9
                            `SHCP_OP_ATTACH: begin
                                attach_reg <= 1'b1; // RULE10
                                smbus_en_reg <= 1'b0;
                            end
                            `SHCP_OP_ATTACH_SMB: attach_reg <= 1'b1; // RULE10
                            default: begin // RULE18
                            end
                        endcase
                    end
                end
                EX_RUN: begin
                    exec_reg <= EX_IDLE;
                    ram[`SHCP_IDX_STATUS] <= `SHCP_ST_OK; // RULE13
                    case (xcode) // RULE11 RULE12
                        `SHCP_XC_SET_ADDR: slave_addr_reg <= xparam[`SHCP_DEFAULT_BIT] ?
                                default_addr_reg : xparam[6:0]; // RULE17
                        `SHCP_XC_GET_DEF: ram[`SHCP_IDX_PARAM] <= {1'b0, default_addr_reg}; // RULE14
                        `SHCP_XC_HUB_INFO: ram[`SHCP_IDX_PARAM] <= hub_info;
                        `SHCP_XC_PS_MASK: ram[`SHCP_IDX_PARAM] <= pswitch_mask;
                        `SHCP_XC_CONNECT, `SHCP_XC_POWER, `SHCP_XC_DPDM: begin
                            for (int i = 0; i < NUM_PORTS; i++) begin
                                ram[RAM_AW'(`SHCP_IDX_RESULT + i)] <= xparam[i] ? port_byte(xcode, i) : 8'h00; // RULE14
                            end
                        end
                        `SHCP_XC_FORCE_DIS: begin
                            for (int i = 0; i < NUM_PORTS; i++) begin
                                if (xparam[i] && ram[RAM_AW'(`SHCP_IDX_RESULT + i)][`SHCP_OVERWRITE_BIT]) begin
                                    port_dis_reg[i*3 +: 3] <= ram[RAM_AW'(`SHCP_IDX_RESULT + i)][2:0];
                                end
                            end
                        end
                        `SHCP_XC_PS_BYTE_RD, `SHCP_XC_PS_BYTE_WR, `SHCP_XC_PS_BLK_RD, `SHCP_XC_PS_BLK_WR: begin
                            // block forms move one byte per command; longer runs need repeats
                            ram[`SHCP_IDX_STATUS] <= 8'h00;
                            ps_req_reg <= 1'b1;
                            ps_wr_reg <= xcode[0];
                            ps_addr_reg <= xparam;
                            ps_wdata_reg <= ram[`SHCP_IDX_RESULT];
                            exec_reg <= EX_WAIT;
                        end
                        default: ram[`SHCP_IDX_STATUS] <= `SHCP_ST_BAD; // RULE13
                    endcase
                end
                EX_WAIT: begin
                    if (pswitch_ack) begin
                        if (!ps_wr_reg) begin
                            ram[`SHCP_IDX_RESULT] <= pswitch_rdata; // RULE14
                        end
                        ram[`SHCP_IDX_STATUS] <= `SHCP_ST_OK; // RULE13
                        exec_reg <= EX_IDLE;
                    end
                end
                default: exec_reg <= EX_IDLE;
            endcase
        end
    end

    assign serial_management_data_line_out = sda_out_reg;
    assign serial_management_data_line_oe = sda_oe_reg;
    assign pswitch_req = ps_req_reg;
    assign pswitch_write = ps_wr_reg;
    assign pswitch_addr = ps_addr_reg;
    assign pswitch_wdata = ps_wdata_reg;
    assign port_disable = port_dis_reg;
    assign mcu_reboot = reboot_reg;
    assign cfg_access = cfg_reg;
    assign usb_attach = attach_reg;
    assign smbus_enable = smbus_en_reg;
    assign exec_busy = busy_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic byte_end;
    assign byte_end = fall_ev && bit_cnt_reg == 4'h8 && !start_ev && !stop_ev;
    AST_FOREIGN_ADDR: assert property (byte_end && phase_reg == PH_ADDR && rx_reg[7:1] != slave_addr_reg // RULE1
        |=> !sda_oe_reg && phase_reg == PH_IGNORE) else $error("foreign address acknowledged");
    AST_OFS_HIGH: assert property (byte_end && phase_reg == PH_OFS_HI // RULE2
        |=> phase_reg == PH_OFS_LO && ofs_reg[15:8] == $past(rx_reg)) else $error("offset high byte lost");
    AST_MSB_FIRST: assert property (rise_ev && !start_ev && !stop_ev && phase_reg != PH_IDLE && bit_cnt_reg < 4'h8 // RULE3
        |=> rx_reg[0] == $past(link_bit_reg) && rx_reg[7:1] == $past(rx_reg[6:0])) else $error("bit order wrong");
    AST_COUNT_LIMIT: assert property (byte_end && phase_reg == PH_COUNT && !special_reg // RULE6
        && rx_reg > `SHCP_BLOCK_MAX |=> phase_reg == PH_IGNORE && !sda_oe_reg) else $error("oversize count taken");
    AST_READ_DRIVE: assert property (fall_ev && !start_ev && !stop_ev && phase_reg == PH_RDATA // RULE7
        && bit_cnt_reg != 4'h0 && bit_cnt_reg != 4'h8 |=> sda_oe_reg == !$past(tx_reg[7])) else $error("read bit wrong");
    AST_GO_AFTER_STOP: assert property (op_go_reg |-> $past(stop_ev) && $past(term_reg)) // RULE18
        else $error("opcode acted without terminator and stop");
    AST_REBOOT: assert property (op_go_reg && exec_reg == EX_IDLE && ofs_reg == `SHCP_OP_REBOOT // RULE9
        |=> mcu_reboot ##1 !mcu_reboot) else $error("reboot pulse wrong");
    AST_ATTACH: assert property (op_go_reg && exec_reg == EX_IDLE && ofs_reg == `SHCP_OP_ATTACH // RULE10
        |=> usb_attach && !smbus_enable) else $error("attach did not drop access");
    AST_STATUS: assert property (exec_reg == EX_RUN && xcode[7:2] != 6'h21 // RULE13
        |=> exec_reg == EX_IDLE && ram[`SHCP_IDX_STATUS] != 8'h00) else $error("status not written");
    AST_SET_ADDR: assert property (exec_reg == EX_RUN && xcode == `SHCP_XC_SET_ADDR && !xparam[7] // RULE17
        |=> slave_addr_reg == $past(xparam[6:0])) else $error("address not replaced");
    COV_WRITE: cover property (byte_end && phase_reg == PH_WDATA ##[1:300] stop_ev);
    COV_READ: cover property (phase_reg == PH_RDATA ##[1:1000] stop_ev);
    COV_EXT: cover property (exec_reg == EX_RUN ##1 exec_reg == EX_IDLE);
endmodule
`default_nettype wire

/* File: pkg/shcp_map.svh */
`ifndef SHCP_MAP_SVH
`define SHCP_MAP_SVH
// ----------------------------------------
// addresses and buffer layout
// ----------------------------------------
`define SHCP_ADDR_A 7'h2C
`define SHCP_ADDR_B 7'h2D
`define SHCP_IDX_CODE 0
`define SHCP_IDX_STATUS 1
`define SHCP_IDX_PARAM 2
`define SHCP_IDX_RESULT 3
`define SHCP_BLOCK_MAX 8'h20
`define SHCP_TERM_BYTE 8'h00
`define SHCP_DEFAULT_BIT 7
`define SHCP_OVERWRITE_BIT 7
// ----------------------------------------
// special opcodes
// ----------------------------------------
`define SHCP_OP_REBOOT 16'h9936
`define SHCP_OP_CFG 16'h9937
`define SHCP_OP_EXT 16'h993E
`define SHCP_OP_ATTACH 16'hAA55
`define SHCP_OP_ATTACH_SMB 16'hAA56
// ----------------------------------------
// extended command codes and status
// ----------------------------------------
`define SHCP_XC_SET_ADDR 8'h00
`define SHCP_XC_GET_DEF 8'h01
`define SHCP_XC_HUB_INFO 8'h02
`define SHCP_XC_PS_MASK 8'h03
`define SHCP_XC_CONNECT 8'h80
`define SHCP_XC_POWER 8'h81
`define SHCP_XC_FORCE_DIS 8'h82
`define SHCP_XC_DPDM 8'h83
`define SHCP_XC_PS_BYTE_RD 8'h84
`define SHCP_XC_PS_BYTE_WR 8'h85
`define SHCP_XC_PS_BLK_RD 8'h86
`define SHCP_XC_PS_BLK_WR 8'h87
`define SHCP_ST_OK 8'h01
`define SHCP_ST_BAD 8'h02
`endif

/* File: pkg/shcp_pkg.sv */
package shcp_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_ADDR = 3'h1,
        PH_OFS_HI = 3'h3,
        PH_OFS_LO = 3'h2,
        PH_COUNT = 3'h6,
        PH_WDATA = 3'h7,
        PH_RDATA = 3'h5,
        PH_IGNORE = 3'h4
    } shcp_phase_type;
    typedef enum logic [1:0] {
        EX_IDLE = 2'h0,
        EX_RUN = 2'h1,
        EX_WAIT = 2'h3
    } shcp_exec_type;
endpackage
